// File: design/rpf_rx_pause_filter.sv
// Summary of operation
// - forward control frames when enabled, else drop
// - acknowledge bus used only when waiting enabled
// - nine pause enables, one per class
// - pause enables mask only user outputs
// - global control processed only when enabled
// - global multicast destination check when enabled
// - global unicast destination check when enabled
// - unicast destination address is 48 bits
// - global source address check when enabled
// - source address is 48 bits
// - global ethertype must equal configured value
// - global opcode within configured min and max
// - priority control processed only when enabled
// - priority multicast, unicast, source checks enabled separately
// - multicast destination address is 48 bits
// - priority opcode within configured min and max
module rpf_rx_pause_filter
  import rpf_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [rpf_pkg::ADDR_W-1:0] i_addr,
  input wire logic [rpf_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [rpf_pkg::DATA_W-1:0] o_rd_data,
  input wire logic i_hdr_valid,
  input wire logic i_hdr_is_ctrl,
  input wire logic [rpf_pkg::MAC_W-1:0] i_hdr_da,
  input wire logic [rpf_pkg::MAC_W-1:0] i_hdr_sa,
  input wire logic [rpf_pkg::HALF_W-1:0] i_hdr_etype,
  input wire logic [rpf_pkg::HALF_W-1:0] i_hdr_opcode,
  input wire logic [rpf_pkg::PRIO_N-1:0] i_hdr_prio_vec,
  input wire logic [rpf_pkg::CLASS_N-1:0] i_pause_ack,
  output logic o_hdr_done,
  output logic o_frame_keep,
  output logic o_gcp_hit,
  output logic o_pcp_hit,
  output logic [rpf_pkg::CLASS_N-1:0] o_pause_pending,
  output logic [rpf_pkg::CLASS_N-1:0] o_pause_user
);
  import rpf_pkg::*;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [CLASS_N-1:0] pause_en;
    logic [MAC_W-1:0] ucast;
    logic [MAC_W-1:0] mcast;
    logic [MAC_W-1:0] sa;
    logic [HALF_W-1:0] gcp_etype;
    logic [HALF_W-1:0] gcp_opmin;
    logic [HALF_W-1:0] gcp_opmax;
    logic [HALF_W-1:0] pcp_etype;
    logic [HALF_W-1:0] pcp_opmin;
    logic [HALF_W-1:0] pcp_opmax;
    logic [CLASS_N-1:0] pending;
    logic [CLASS_N-1:0] user;
    logic done;
    logic keep;
    logic gcp_hit;
    logic pcp_hit;
    logic [DATA_W-1:0] rd_data;
  } rpf_state_s;

  rpf_state_s st;
  rpf_state_s next_st;
  logic gcp_match;
  logic pcp_match;
  logic [CLASS_N-1:0] set_vec;
  logic [CLASS_N-1:0] held_vec;

  // both categories share the address registers; a frame whose fields
  // satisfy both sets of checks counts as both
  rpf_ctrl_match u_gcp_match (
    .i_enable(st.ctrl[B_GCP_EN]),
    .i_chk_mcast(st.ctrl[B_GCP_MCAST]),
    .i_chk_ucast(st.ctrl[B_GCP_UCAST]),
    .i_chk_sa(st.ctrl[B_GCP_SA]),
    .i_chk_etype(st.ctrl[B_GCP_ETYPE]),
    .i_chk_opcode(st.ctrl[B_GCP_OPC]),
    .i_mcast_addr(st.mcast),
    .i_ucast_addr(st.ucast),
    .i_src_addr(st.sa),
    .i_etype(st.gcp_etype),
    .i_opcode_min(st.gcp_opmin),
    .i_opcode_max(st.gcp_opmax),
    .i_frm_da(i_hdr_da),
    .i_frm_sa(i_hdr_sa),
    .i_frm_etype(i_hdr_etype),
    .i_frm_opcode(i_hdr_opcode),
    .o_hit(gcp_match)
  );

  rpf_ctrl_match u_pcp_match (
    .i_enable(st.ctrl[B_PCP_EN]),
    .i_chk_mcast(st.ctrl[B_PCP_MCAST]),
    .i_chk_ucast(st.ctrl[B_PCP_UCAST]),
    .i_chk_sa(st.ctrl[B_PCP_SA]),
    .i_chk_etype(st.ctrl[B_PCP_ETYPE]),
    .i_chk_opcode(st.ctrl[B_PCP_OPC]),
    .i_mcast_addr(st.mcast),
    .i_ucast_addr(st.ucast),
    .i_src_addr(st.sa),
    .i_etype(st.pcp_etype),
    .i_opcode_min(st.pcp_opmin),
    .i_opcode_max(st.pcp_opmax),
    .i_frm_da(i_hdr_da),
    .i_frm_sa(i_hdr_sa),
    .i_frm_etype(i_hdr_etype),
    .i_frm_opcode(i_hdr_opcode),
    .o_hit(pcp_match)
  );

  always_comb begin
    next_st = st;
    // configuration writes
    if (i_wr) begin
      case (i_addr)
        OFS_CTRL: begin
          next_st.ctrl = i_wr_data[CTRL_W-1:0];
        end
        OFS_PAUSE_EN: begin
          next_st.pause_en = i_wr_data[CLASS_N-1:0];
        end
        OFS_UCAST_LO: begin
          next_st.ucast[DATA_W-1:0] = i_wr_data;
        end
        OFS_UCAST_HI: begin
          next_st.ucast[MAC_W-1:DATA_W] = i_wr_data[HALF_W-1:0];
        end
        OFS_MCAST_LO: begin
          next_st.mcast[DATA_W-1:0] = i_wr_data;
        end
        OFS_MCAST_HI: begin
          next_st.mcast[MAC_W-1:DATA_W] = i_wr_data[HALF_W-1:0];
        end
        OFS_SA_LO: begin
          next_st.sa[DATA_W-1:0] = i_wr_data;
        end
        OFS_SA_HI: begin
          next_st.sa[MAC_W-1:DATA_W] = i_wr_data[HALF_W-1:0];
        end
        OFS_GCP_ETYPE: begin
          next_st.gcp_etype = i_wr_data[HALF_W-1:0];
        end
        OFS_GCP_OPC: begin
          next_st.gcp_opmin = i_wr_data[HALF_W-1:0];
          next_st.gcp_opmax = i_wr_data[DATA_W-1:OPC_MAX_LSB];
        end
        OFS_PCP_ETYPE: begin
          next_st.pcp_etype = i_wr_data[HALF_W-1:0];
        end
        OFS_PCP_OPC: begin
          next_st.pcp_opmin = i_wr_data[HALF_W-1:0];
          next_st.pcp_opmax = i_wr_data[DATA_W-1:OPC_MAX_LSB];
        end
        default: begin
        end
      endcase
    end

    // read data stands one cycle only; unmapped reads return zero
    next_st.rd_data = RD_IDLE;
    if (i_rd) begin
      case (i_addr)
        OFS_CTRL: next_st.rd_data[CTRL_W-1:0] = st.ctrl;
        OFS_PAUSE_EN: next_st.rd_data[CLASS_N-1:0] = st.pause_en;
        OFS_UCAST_LO: next_st.rd_data = st.ucast[DATA_W-1:0];
        OFS_UCAST_HI: next_st.rd_data[HALF_W-1:0] = st.ucast[MAC_W-1:DATA_W];
        OFS_MCAST_LO: next_st.rd_data = st.mcast[DATA_W-1:0];
        OFS_MCAST_HI: next_st.rd_data[HALF_W-1:0] = st.mcast[MAC_W-1:DATA_W];
        OFS_SA_LO: next_st.rd_data = st.sa[DATA_W-1:0];
        OFS_SA_HI: next_st.rd_data[HALF_W-1:0] = st.sa[MAC_W-1:DATA_W];
        OFS_GCP_ETYPE: next_st.rd_data[HALF_W-1:0] = st.gcp_etype;
        OFS_GCP_OPC: next_st.rd_data = {st.gcp_opmax, st.gcp_opmin};
        OFS_PCP_ETYPE: next_st.rd_data[HALF_W-1:0] = st.pcp_etype;
        OFS_PCP_OPC: next_st.rd_data = {st.pcp_opmax, st.pcp_opmin};
        OFS_STATUS: next_st.rd_data[CLASS_N-1:0] = st.pending;
        default: next_st.rd_data = RD_IDLE;
      endcase
    end

    // frame verdict, one cycle after the header
    next_st.done = i_hdr_valid;
    next_st.gcp_hit = i_hdr_valid && i_hdr_is_ctrl && gcp_match;
    next_st.pcp_hit = i_hdr_valid && i_hdr_is_ctrl && pcp_match;
    next_st.keep = i_hdr_valid &&
                   (!i_hdr_is_ctrl || st.ctrl[B_FWD_CTRL]);

    // new indication wins over an acknowledge in the same cycle
    set_vec = '0;
    set_vec[GLOBAL_CLASS] = next_st.gcp_hit;
    if (next_st.pcp_hit) begin
      set_vec[PRIO_N-1:0] = i_hdr_prio_vec;
    end
    // ack bits ignored unless waiting is on; a pulse otherwise
    if (st.ctrl[B_CHECK_ACK]) begin
      held_vec = st.pending & ~i_pause_ack;
    end else begin
      held_vec = '0;
    end
    next_st.pending = set_vec | held_vec;
    // masking here keeps the pending state independent of the enables
    next_st.user = next_st.pending & next_st.pause_en;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st.ctrl <= CTRL_RST;
      st.pause_en <= PAUSE_EN_RST;
      st.ucast <= MAC_RST;
      st.mcast <= MAC_RST;
      st.sa <= MAC_RST;
      st.gcp_etype <= HALF_RST;
      st.gcp_opmin <= HALF_RST;
      st.gcp_opmax <= HALF_RST;
      st.pcp_etype <= HALF_RST;
      st.pcp_opmin <= HALF_RST;
      st.pcp_opmax <= HALF_RST;
      st.pending <= '0;
      st.user <= '0;
      st.done <= 1'b0;
      st.keep <= 1'b0;
      st.gcp_hit <= 1'b0;
      st.pcp_hit <= 1'b0;
      st.rd_data <= RD_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign o_rd_data = st.rd_data;
  assign o_hdr_done = st.done;
  assign o_frame_keep = st.keep;
  assign o_gcp_hit = st.gcp_hit;
  assign o_pcp_hit = st.pcp_hit;
  assign o_pause_pending = st.pending;
  assign o_pause_user = st.user;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_hdr_in;
    i_hdr_valid && i_hdr_is_ctrl;
  endsequence

  sequence s_verdict_gcp;
    o_hdr_done && o_gcp_hit && o_pause_pending[GLOBAL_CLASS];
  endsequence

  sequence s_verdict_pcp;
    o_hdr_done && o_pcp_hit &&
      ((o_pause_pending[PRIO_N-1:0] & $past(i_hdr_prio_vec)) ==
       $past(i_hdr_prio_vec));
  endsequence

  a_fwd_keep: assert property (
    i_hdr_valid |=> o_hdr_done &&
      (o_frame_keep == (!$past(i_hdr_is_ctrl) ||
                        $past(st.ctrl[B_FWD_CTRL]))))
    else $error("control forward decision wrong");

  a_ack_ignored: assert property (
    (!st.ctrl[B_CHECK_ACK] && !i_hdr_valid) |=> o_pause_pending == '0)
    else $error("pending held without ack waiting");

  a_ack_hold: assert property (
    st.ctrl[B_CHECK_ACK] |=>
      ((o_pause_pending & $past(st.pending & ~i_pause_ack)) ==
       $past(st.pending & ~i_pause_ack)))
    else $error("unacknowledged pause indication lost");

  a_user_mask: assert property (
    o_pause_user == (o_pause_pending & st.pause_en))
    else $error("user pause view not masked pending");

  a_gcp_gate: assert property (
    !st.ctrl[B_GCP_EN] |=> !o_gcp_hit)
    else $error("global control hit while disabled");

  a_pcp_gate: assert property (
    !st.ctrl[B_PCP_EN] |=> !o_pcp_hit)
    else $error("priority control hit while disabled");

  a_gcp_ucast: assert property (
    (st.ctrl[B_GCP_UCAST] && !st.ctrl[B_GCP_MCAST] &&
     i_hdr_da != st.ucast) |=> !o_gcp_hit)
    else $error("global hit despite unicast mismatch");

  a_gcp_mcast: assert property (
    (st.ctrl[B_GCP_MCAST] && !st.ctrl[B_GCP_UCAST] &&
     i_hdr_da != st.mcast) |=> !o_gcp_hit)
    else $error("global hit despite multicast mismatch");

  a_gcp_src: assert property (
    (st.ctrl[B_GCP_SA] && i_hdr_sa != st.sa) |=> !o_gcp_hit)
    else $error("global hit despite source mismatch");

  a_pcp_src: assert property (
    (st.ctrl[B_PCP_SA] && i_hdr_sa != st.sa) |=> !o_pcp_hit)
    else $error("priority hit despite source mismatch");

  a_gcp_etype: assert property (
    (st.ctrl[B_GCP_ETYPE] && i_hdr_etype != st.gcp_etype) |=> !o_gcp_hit)
    else $error("global hit despite ethertype mismatch");

  a_gcp_opcode: assert property (
    (st.ctrl[B_GCP_OPC] && (i_hdr_opcode < st.gcp_opmin ||
     i_hdr_opcode > st.gcp_opmax)) |=> !o_gcp_hit)
    else $error("global hit with opcode out of range");

  a_pcp_opcode: assert property (
    (st.ctrl[B_PCP_OPC] && (i_hdr_opcode < st.pcp_opmin ||
     i_hdr_opcode > st.pcp_opmax)) |=> !o_pcp_hit)
    else $error("priority hit with opcode out of range");

  a_gcp_classify: assert property (
    (s_hdr_in ##0 gcp_match) |=> s_verdict_gcp)
    else $error("qualified global frame not classified");

  a_pcp_classify: assert property (
    (s_hdr_in ##0 pcp_match) |=> s_verdict_pcp)
    else $error("qualified priority frame not classified");

  a_pcp_mcast: assert property (
    (st.ctrl[B_PCP_MCAST] && !st.ctrl[B_PCP_UCAST] &&
     i_hdr_da != st.mcast) |=> !o_pcp_hit)
    else $error("priority hit despite multicast mismatch");

  a_pcp_ucast: assert property (
    (st.ctrl[B_PCP_UCAST] && !st.ctrl[B_PCP_MCAST] &&
     i_hdr_da != st.ucast) |=> !o_pcp_hit)
    else $error("priority hit despite unicast mismatch");

  a_ack_clear: assert property (
    (st.ctrl[B_CHECK_ACK] && !i_hdr_valid) |=>
      o_pause_pending == $past(st.pending & ~i_pause_ack))
    else $error("acknowledged pause indication not cleared");

  a_rd_idle: assert property (
    !i_rd |=> o_rd_data == RD_IDLE)
    else $error("read data outside its cycle");
endmodule : rpf_rx_pause_filter

// File: design/rpf_pkg.sv
package rpf_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int MAC_W = 48;
  localparam int HALF_W = 16;
  localparam int CLASS_N = 9;
  localparam int PRIO_N = 8;
  localparam int GLOBAL_CLASS = 8;
  localparam int CTRL_W = 14;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PAUSE_EN = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_UCAST_LO = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_UCAST_HI = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_MCAST_LO = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MCAST_HI = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_SA_LO = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_SA_HI = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_GCP_ETYPE = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_GCP_OPC = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_PCP_ETYPE = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_PCP_OPC = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h30;

  // control register bit positions
  localparam int B_FWD_CTRL = 0;
  localparam int B_CHECK_ACK = 1;
  localparam int B_GCP_EN = 2;
  localparam int B_GCP_MCAST = 3;
  localparam int B_GCP_UCAST = 4;
  localparam int B_GCP_SA = 5;
  localparam int B_GCP_ETYPE = 6;
  localparam int B_GCP_OPC = 7;
  localparam int B_PCP_EN = 8;
  localparam int B_PCP_MCAST = 9;
  localparam int B_PCP_UCAST = 10;
  localparam int B_PCP_SA = 11;
  localparam int B_PCP_ETYPE = 12;
  localparam int B_PCP_OPC = 13;
  // opcode register: min low half, max high half
  localparam int OPC_MAX_LSB = 16;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 14'h0000;
  localparam logic [CLASS_N-1:0] PAUSE_EN_RST = 9'h1FF;
  localparam logic [MAC_W-1:0] MAC_RST = 48'h000000000000;
  localparam logic [HALF_W-1:0] HALF_RST = 16'h0000;
  localparam logic [DATA_W-1:0] RD_IDLE = 32'h00000000;
endpackage : rpf_pkg

// File: design/rpf_ctrl_match.sv
module rpf_ctrl_match
  import rpf_pkg::*;
(
  input wire logic i_enable,
  input wire logic i_chk_mcast,
  input wire logic i_chk_ucast,
  input wire logic i_chk_sa,
  input wire logic i_chk_etype,
  input wire logic i_chk_opcode,
  input wire logic [rpf_pkg::MAC_W-1:0] i_mcast_addr,
  input wire logic [rpf_pkg::MAC_W-1:0] i_ucast_addr,
  input wire logic [rpf_pkg::MAC_W-1:0] i_src_addr,
  input wire logic [rpf_pkg::HALF_W-1:0] i_etype,
  input wire logic [rpf_pkg::HALF_W-1:0] i_opcode_min,
  input wire logic [rpf_pkg::HALF_W-1:0] i_opcode_max,
  input wire logic [rpf_pkg::MAC_W-1:0] i_frm_da,
  input wire logic [rpf_pkg::MAC_W-1:0] i_frm_sa,
  input wire logic [rpf_pkg::HALF_W-1:0] i_frm_etype,
  input wire logic [rpf_pkg::HALF_W-1:0] i_frm_opcode,
  output logic o_hit
);
  import rpf_pkg::*;

  logic da_ok;
  logic sa_ok;
  logic et_ok;
  logic op_ok;

  // both address checks on: either address may match
  always_comb begin
    if (i_chk_mcast && i_chk_ucast) begin
      da_ok = (i_frm_da == i_mcast_addr) || (i_frm_da == i_ucast_addr);
    end else if (i_chk_mcast) begin
      da_ok = (i_frm_da == i_mcast_addr);
    end else if (i_chk_ucast) begin
      da_ok = (i_frm_da == i_ucast_addr);
    end else begin
      da_ok = 1'b1;
    end
    sa_ok = !i_chk_sa || (i_frm_sa == i_src_addr);
    et_ok = !i_chk_etype || (i_frm_etype == i_etype);
    op_ok = !i_chk_opcode ||
            ((i_frm_opcode >= i_opcode_min) &&
             (i_frm_opcode <= i_opcode_max));
    o_hit = i_enable && da_ok && sa_ok && et_ok && op_ok;
  end
endmodule : rpf_ctrl_match

// File: test/rpf_user_model.sv
module rpf_user_model
  import rpf_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [rpf_pkg::CLASS_N-1:0] i_pause_user,
  input wire logic [3:0] i_delay,
  output logic [rpf_pkg::CLASS_N-1:0] o_pause_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  import rpf_pkg::*;
  int cnt[CLASS_N];
  // only the masked view is seen, so a masked class is never acked
  always @(posedge i_clk or posedge i_rst) begin
    for (int c = 0; c < CLASS_N; c++) begin
      if (i_rst) begin
        cnt[c] = 0;
        o_pause_ack[c] <= 1'b0;
      end else if (o_pause_ack[c] || !i_pause_user[c]) begin
        cnt[c] = 0;
        o_pause_ack[c] <= 1'b0;
      end else if (cnt[c] >= int'(i_delay)) begin
        o_pause_ack[c] <= 1'b1;
      end else begin
        cnt[c]++;
      end
    end
  end
endmodule : rpf_user_model

// File: test/rpf_rx_pause_filter_tb_top.sv
module rpf_rx_pause_filter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rpf_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wr_data = 32'h00000000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic h_v = 1'b0;
  logic h_ctrl = 1'b0;
  logic [47:0] h_da = 48'h000000000000;
  logic [47:0] h_sa = 48'h000000000000;
  logic [15:0] h_et = 16'h0000;
  logic [15:0] h_op = 16'h0000;
  logic [7:0] h_pv = 8'h00;
  logic [3:0] dly = 4'h0;
  logic [8:0] ack, pend, pend_o, user_o;
  logic [31:0] rd_o, e_rd;
  logic done_o, keep_o, g_o, p_o, e_done, e_keep, e_g, e_p;
  logic [31:0] rg[13];
  int error_cnt = 0;
  int n_checks = 0;

  always #5 i_clk = ~i_clk;

  rpf_rx_pause_filter u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(rd_o),
    .i_hdr_valid(h_v), .i_hdr_is_ctrl(h_ctrl), .i_hdr_da(h_da),
    .i_hdr_sa(h_sa), .i_hdr_etype(h_et), .i_hdr_opcode(h_op),
    .i_hdr_prio_vec(h_pv), .i_pause_ack(ack), .o_hdr_done(done_o),
    .o_frame_keep(keep_o), .o_gcp_hit(g_o), .o_pcp_hit(p_o),
    .o_pause_pending(pend_o), .o_pause_user(user_o));
  rpf_user_model u_user (.i_clk(i_clk), .i_rst(i_rst),
    .i_pause_user(user_o), .i_delay(dly), .o_pause_ack(ack));

  function automatic logic [31:0] msk(int i);
    case (i)
      0: return 32'h00003FFF;
      1: return 32'h000001FF;
      2, 4, 6, 9, 11: return 32'hFFFFFFFF;
      3, 5, 7, 8, 10: return 32'h0000FFFF;
      default: return 32'h00000000;
    endcase
  endfunction : msk

  function automatic logic [31:0] rdv(logic [7:0] a);
    if (a[1:0] != 2'h0 || a > OFS_STATUS) return 32'h00000000;
    if (a == OFS_STATUS) return {23'h000000, pend};
    return rg[a >> 2];
  endfunction : rdv

  // b: category enable bit, e: index of its ethertype word
  function automatic logic hit(int b, int e);
    logic [31:0] c;
    logic ok;
    c = rg[0];
    ok = c[b] & h_ctrl;
    if (c[b+1] | c[b+2]) begin
      ok &= (c[b+1] && h_da == {rg[5][15:0], rg[4]})
        || (c[b+2] && h_da == {rg[3][15:0], rg[2]});
    end
    if (c[b+3]) ok &= h_sa == {rg[7][15:0], rg[6]};
    if (c[b+4]) ok &= h_et == rg[e][15:0];
    if (c[b+5]) begin
      ok &= h_op >= rg[e+1][15:0] && h_op <= rg[e+1][31:16];
    end
    return ok;
  endfunction : hit

  // register writes land after the header decision of the same edge
  always @(posedge i_clk or posedge i_rst) begin : mdl
    logic g, p;
    if (i_rst) begin
      foreach (rg[k]) rg[k] = 32'h00000000;
      rg[1] = 32'h000001FF;
      pend = 9'h000;
      e_rd = 32'h00000000;
      {e_done, e_keep, e_g, e_p} = 4'h0;
    end else begin
      g = h_v && hit(B_GCP_EN, 8);
      p = h_v && hit(B_PCP_EN, 10);
      e_done = h_v;
      e_keep = h_v && (!h_ctrl || rg[0][B_FWD_CTRL]);
      {e_g, e_p} = {g, p};
      e_rd = i_rd ? rdv(i_addr) : 32'h00000000;
      if (rg[0][B_CHECK_ACK]) pend = (pend & ~ack) | {g, p ? h_pv : 8'h00};
      else pend = {g, p ? h_pv : 8'h00};
      if (i_wr && i_addr[1:0] == 2'h0 && i_addr < OFS_STATUS) begin
        rg[i_addr >> 2] = i_wr_data & msk(int'(i_addr >> 2));
      end
    end
  end

  task chk(string nm, logic [47:0] seen, logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  always @(negedge i_clk) begin
    if (!i_rst) begin
      chk("rd_data", rd_o, e_rd);
      chk("hdr_done", done_o, e_done);
      chk("frame_keep", keep_o, e_keep);
      chk("gcp_hit", g_o, e_g);
      chk("pcp_hit", p_o, e_p);
      chk("pause_pending", pend_o, pend);
      chk("pause_user", user_o, pend & rg[1][8:0]);
    end
  end

  function automatic logic [47:0] p3(logic [47:0] x, logic [47:0] y);
    int r;
    r = $urandom % 3;
    return r == 0 ? x : r == 1 ? y : 48'({$urandom, $urandom});
  endfunction : p3

  // fields biased towards configured values so that checks do pass
  task step();
    int r;
    logic [31:0] o;
    @(posedge i_clk);
    r = $urandom % 8;
    o = ($urandom % 2) ? rg[9] : rg[11];
    i_wr <= r == 0;
    i_rd <= r == 1;
    i_addr <= 8'(($urandom % 15) * 4);
    i_wr_data <= $urandom;
    h_v <= r > 1;
    h_ctrl <= $urandom % 4 != 0;
    h_da <= p3({rg[3][15:0], rg[2]}, {rg[5][15:0], rg[4]});
    h_sa <= p3({rg[7][15:0], rg[6]}, {rg[7][15:0], rg[6]});
    h_et <= 16'(p3(48'(rg[8]), 48'(rg[10])));
    h_op <= 16'(int'(($urandom % 2) ? o[31:16] : o[15:0]) + $urandom % 3 - 1);
    h_pv <= 8'($urandom);
    if ($urandom % 256 == 0) dly <= 4'($urandom % 6);
  endtask : step

  task rst_pulse();
    @(posedge i_clk);
    i_rst <= 1'b1;
    {i_wr, i_rd, h_v} <= 3'h0;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
  endtask : rst_pulse

  task end_of_test();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  initial begin
    void'($urandom(78));
    rst_pulse();
    repeat (2) begin
      repeat (10000) step();
      rst_pulse();
    end
    end_of_test();
  end

  // the run needs about 20100 cycles
  initial begin
    #500us;
    error_cnt++;
    end_of_test();
  end
endmodule : rpf_rx_pause_filter_tb_top
